// ---- core/spwm_pkg.sv ----
// Package: constants and types for the synchronized PWM channel
package spwm_pkg;
   // Widths
   localparam int TB_W = 24; // Timebase counter width
   localparam int VAL_W = 22; // Period, high time and offset width
   localparam int DUTY_W = 14; // Duty setting width
   localparam int MA_W = 10; // Data memory address width
   localparam int PROD_W = 36; // Period times duty
   localparam int AW = 8; // Register bus address width
   // Duty scale: 10000 means fully high
   localparam logic [13:0] DUTY_FULL = 14'h2710;
   // Division steps, one per product bit
   localparam logic [5:0] DIV_STEPS = 6'h24;
   // Register byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PERIOD = 8'h04;
   localparam logic [7:0] A_DUTY = 8'h08;
   localparam logic [7:0] A_OFFSET = 8'h0C;
   localparam logic [7:0] A_REF_PTR = 8'h10;
   localparam logic [7:0] A_STAMP_ADDR = 8'h14;
   localparam logic [7:0] A_LINK_MASK = 8'h18;
   localparam logic [7:0] A_STATUS = 8'h1C;
   localparam logic [7:0] A_RISE_STAMP = 8'h20;
   localparam logic [7:0] A_HIGH_TIME = 8'h24;
   // Control bit positions
   localparam int CB_EN = 0; // Channel runs
   localparam int CB_SLAVE = 1; // Slave mode
   localparam int CB_TB = 2; // Second timebase counter
   localparam int CB_REF = 3; // Master starts from memory reference
   localparam int CB_FALL = 4; // Requests on falling edges too
   localparam int CTRL_W = 5;
   // Reset values
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [21:0] PERIOD_RST = 22'h000000;
   localparam logic [13:0] DUTY_RST = 14'h0000;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Channel states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOW = 2'b01,
      ST_HIGH = 2'b10
   } spwm_state_t;
endpackage

// ---- core/spwm_high_time.sv ----
// High time calculator: period times duty divided by full scale
`timescale 1ns/1ps
module spwm_high_time (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_b,
   // Request
   input wire logic i_start,
   input wire logic [spwm_pkg::VAL_W-1:0] i_period,
   input wire logic [spwm_pkg::DUTY_W-1:0] i_duty,
   // Result
   output logic o_busy,
   output logic o_done,
   output logic [spwm_pkg::VAL_W-1:0] o_high
);
   logic [spwm_pkg::PROD_W-1:0] num; // Dividend, becomes quotient
   logic [14:0] rem; // Partial remainder
   logic [5:0] step; // Steps left
   logic [spwm_pkg::PROD_W-1:0] chk_num; // Product kept for checking

   // Shifted remainder and trial subtract
   wire [14:0] rem_sh = {rem[13:0], num[spwm_pkg::PROD_W-1]};
   wire fits = rem_sh >= {1'b0, spwm_pkg::DUTY_FULL};

   // Restoring division by the full-scale duty
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         num <= '0;
         rem <= '0;
         step <= '0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_high <= '0;
      end else begin
         o_done <= 1'b0;
         if (i_start && !o_busy) begin
            // Load the product
            num <= spwm_pkg::PROD_W'(i_period) * spwm_pkg::PROD_W'(i_duty);
            rem <= '0;
            step <= spwm_pkg::DIV_STEPS;
            o_busy <= 1'b1;
         end else if (o_busy) begin
            // One quotient bit per cycle
            rem <= fits ? rem_sh - {1'b0, spwm_pkg::DUTY_FULL} : rem_sh;
            num <= {num[spwm_pkg::PROD_W-2:0], fits};
            step <= step - 6'h01;
            if (step == 6'h01) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
               o_high <= {num[spwm_pkg::VAL_W-2:0], fits};
            end
         end
      end
   end

   // Product captured for the check below
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         chk_num <= '0;
      end else if (i_start && !o_busy) begin
         chk_num <= spwm_pkg::PROD_W'(i_period) * spwm_pkg::PROD_W'(i_duty);
      end
   end

   property p_quotient;
      @(posedge i_clock) disable iff (!i_rst_b)
      $rose(o_busy) |-> ##36 (o_done &&
         (o_high == spwm_pkg::VAL_W'(chk_num / spwm_pkg::PROD_W'(spwm_pkg::DUTY_FULL))));
   endproperty
   a_quotient: assert property (p_quotient) else $error("High time wrong or late");
endmodule // spwm_high_time

// ---- core/spwm_channel.sv ----
// Synchronized PWM channel, master or slave, with register bus
`timescale 1ns/1ps
// How it works
// - Period and high time rewritable while running
// - Slave rise follows master rise by offset
// - Period, high time, offset are 22 bits
// - Duty from zero to full, both extremes
// - Slave offset may reach one period
// - Master links up to eight slaves per period
// - Slave schedules from memory reference on link
// - Any link source drives a slave
// - Rise writes timebase into stamp location
// - Master rise raises interrupt and DMA request
// - Falling request only when option enabled
// - Period and duty updates not applied coherently
// - Own duty per channel, own slave offset
// - Duty 0 to 10000 in 0.01 percent
// - Immediate start: run timebase plus period
// - Reference start: memory reference plus period
module spwm_channel (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_b,
   // Register bus, write channels
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [spwm_pkg::AW-1:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   // Register bus, read channels
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [spwm_pkg::AW-1:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   // Timebase counters
   input wire logic [spwm_pkg::TB_W-1:0] i_timebase_counter_1,
   input wire logic [spwm_pkg::TB_W-1:0] i_timebase_counter_2,
   // Shared data memory
   output logic [spwm_pkg::MA_W-1:0] o_mem_rd_addr,
   input wire logic [spwm_pkg::TB_W-1:0] i_mem_rd_data,
   output logic o_mem_wr_en,
   output logic [spwm_pkg::MA_W-1:0] o_mem_wr_addr,
   output logic [spwm_pkg::TB_W-1:0] o_mem_wr_data,
   // Links
   input wire logic i_link,
   output logic [7:0] o_link_req,
   // Waveform and requests
   output logic o_pwm,
   output logic o_irq_req,
   output logic o_dma_req
);
   // Modular time compare: target reached when now minus target is not negative
   function automatic logic reached(input logic [spwm_pkg::TB_W-1:0] now,
                                    input logic [spwm_pkg::TB_W-1:0] tgt);
      logic [spwm_pkg::TB_W-1:0] diff;
      diff = now - tgt;
      return !diff[spwm_pkg::TB_W-1];
   endfunction

   // Byte-lane merge of a write into a register word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction

   // Known register addresses
   function automatic logic mapped(input logic [spwm_pkg::AW-1:0] a);
      return (a[1:0] == 2'h0) && (a <= spwm_pkg::A_HIGH_TIME);
   endfunction

   // Configuration registers
   logic [spwm_pkg::CTRL_W-1:0] ctrl; // Control bits
   logic [spwm_pkg::VAL_W-1:0] period; // Period in timebase ticks
   logic [spwm_pkg::DUTY_W-1:0] duty; // Duty, 0 to 10000
   logic [spwm_pkg::VAL_W-1:0] offset; // Slave rise offset
   logic [spwm_pkg::MA_W-1:0] ref_ptr; // Reference or master stamp pointer
   logic [spwm_pkg::MA_W-1:0] stamp_addr; // Own rise stamp location
   logic [7:0] link_mask; // Slaves to link
   // Bus state
   logic aw_held; // Write address waiting
   logic w_held; // Write data waiting
   logic [spwm_pkg::AW-1:0] aw_addr; // Held write address
   logic [31:0] w_data; // Held write data
   logic [3:0] w_strb; // Held byte enables
   // Channel state
   spwm_pkg::spwm_state_t state; // Waveform state
   logic en_q; // Enable one cycle ago
   logic rise_armed; // A rise is scheduled
   logic [spwm_pkg::TB_W-1:0] rise_tgt; // Next rise time
   logic [spwm_pkg::TB_W-1:0] fall_tgt; // Next fall time
   logic [spwm_pkg::VAL_W-1:0] high_time; // Computed high time
   logic recalc; // High time needs recomputing
   // Divider handshake
   logic div_busy;
   logic div_done;
   logic [spwm_pkg::VAL_W-1:0] div_high;
   logic [31:0] rd_word; // Read data selection

   // Control decode
   wire ctl_en = ctrl[spwm_pkg::CB_EN];
   wire ctl_slave = ctrl[spwm_pkg::CB_SLAVE];
   wire ctl_ref = ctrl[spwm_pkg::CB_REF];
   wire ctl_fall = ctrl[spwm_pkg::CB_FALL];
   wire [spwm_pkg::TB_W-1:0] tb_sel =
      ctrl[spwm_pkg::CB_TB] ? i_timebase_counter_2 : i_timebase_counter_1;

   // Bus handshakes
   assign o_awready = !aw_held;
   assign o_wready = !w_held;
   assign o_arready = !o_rvalid;
   wire do_write = aw_held && w_held && !o_bvalid;
   wire wr_ok = do_write && mapped(aw_addr);
   wire rd_take = i_arvalid && o_arready;

   // Write selects
   wire wr_ctrl = wr_ok && (aw_addr == spwm_pkg::A_CTRL);
   wire wr_period = wr_ok && (aw_addr == spwm_pkg::A_PERIOD);
   wire wr_duty = wr_ok && (aw_addr == spwm_pkg::A_DUTY);
   wire wr_offset = wr_ok && (aw_addr == spwm_pkg::A_OFFSET);
   wire wr_ref = wr_ok && (aw_addr == spwm_pkg::A_REF_PTR);
   wire wr_stamp = wr_ok && (aw_addr == spwm_pkg::A_STAMP_ADDR);
   wire wr_link = wr_ok && (aw_addr == spwm_pkg::A_LINK_MASK);

   // Merged write values, duty clamped to full scale
   wire [31:0] duty_m = merge(32'(duty), w_data, w_strb);
   wire [spwm_pkg::DUTY_W-1:0] next_duty =
      (duty_m > 32'(spwm_pkg::DUTY_FULL)) ? spwm_pkg::DUTY_FULL : duty_m[13:0];
   wire [31:0] period_m = merge(32'(period), w_data, w_strb);
   wire [31:0] offset_m = merge(32'(offset), w_data, w_strb);

   // Edge timing
   wire start = ctl_en && !en_q; // Run request
   wire high_nz = high_time != '0; // Zero duty keeps output low
   wire high_full = high_time >= period; // Full duty keeps output high
   wire [spwm_pkg::TB_W-1:0] start_ref = ctl_ref ? i_mem_rd_data : tb_sel;
   wire [spwm_pkg::TB_W-1:0] first_rise = start_ref + spwm_pkg::TB_W'(period);
   wire [spwm_pkg::TB_W-1:0] slave_tgt = i_mem_rd_data + spwm_pkg::TB_W'(offset);
   wire link_take = i_link && ctl_slave && (state != spwm_pkg::ST_IDLE);
   wire fall_evt = (state == spwm_pkg::ST_HIGH) && reached(tb_sel, fall_tgt);
   wire rise_evt = (state != spwm_pkg::ST_IDLE) && rise_armed &&
      reached(tb_sel, rise_tgt) && !fall_evt;

   // Reference pointer selects the memory word read
   assign o_mem_rd_addr = ref_ptr;

   // Write address and data may arrive in either order
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response, error for unmapped addresses
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_bvalid <= 1'b0;
         o_bresp <= spwm_pkg::RESP_OKAY;
      end else if (do_write) begin
         o_bvalid <= 1'b1;
         o_bresp <= mapped(aw_addr) ? spwm_pkg::RESP_OKAY : spwm_pkg::RESP_SLVERR;
      end else if (i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   // Configuration writes; period, duty, offset honour byte enables, ctrl and link mask need lane 0, pointers ignore them
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl <= spwm_pkg::CTRL_RST;
         period <= spwm_pkg::PERIOD_RST;
         duty <= spwm_pkg::DUTY_RST;
         offset <= '0;
         ref_ptr <= '0;
         stamp_addr <= '0;
         link_mask <= '0;
      end else begin
         if (wr_ctrl && w_strb[0]) begin
            ctrl <= w_data[spwm_pkg::CTRL_W-1:0];
         end
         if (wr_period) begin
            period <= period_m[spwm_pkg::VAL_W-1:0];
         end
         if (wr_duty) begin
            duty <= next_duty;
         end
         if (wr_offset) begin
            offset <= offset_m[spwm_pkg::VAL_W-1:0];
         end
         if (wr_ref) begin
            ref_ptr <= w_data[spwm_pkg::MA_W-1:0];
         end
         if (wr_stamp) begin
            stamp_addr <= w_data[spwm_pkg::MA_W-1:0];
         end
         if (wr_link && w_strb[0]) begin
            link_mask <= w_data[7:0];
         end
      end
   end

   // Read data selection
   always_comb begin
      unique case (i_araddr)
         spwm_pkg::A_CTRL: rd_word = 32'(ctrl);
         spwm_pkg::A_PERIOD: rd_word = 32'(period);
         spwm_pkg::A_DUTY: rd_word = 32'(duty);
         spwm_pkg::A_OFFSET: rd_word = 32'(offset);
         spwm_pkg::A_REF_PTR: rd_word = 32'(ref_ptr);
         spwm_pkg::A_STAMP_ADDR: rd_word = 32'(stamp_addr);
         spwm_pkg::A_LINK_MASK: rd_word = 32'(link_mask);
         spwm_pkg::A_STATUS: rd_word = 32'({div_busy, state, o_pwm});
         spwm_pkg::A_RISE_STAMP: rd_word = 32'(o_mem_wr_data);
         spwm_pkg::A_HIGH_TIME: rd_word = 32'(high_time);
         default: rd_word = 32'h00000000;
      endcase
   end

   // Read answer, held until taken
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= spwm_pkg::RESP_OKAY;
      end else if (rd_take) begin
         o_rvalid <= 1'b1;
         o_rdata <= rd_word;
         o_rresp <= mapped(i_araddr) ? spwm_pkg::RESP_OKAY : spwm_pkg::RESP_SLVERR;
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end

   // High time refresh; a write in the cycle a division starts wins over the clear
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         recalc <= 1'b0;
         high_time <= '0;
      end else begin
         if (!div_busy && recalc) begin
            recalc <= 1'b0;
         end
         if (wr_period || wr_duty || start) begin
            recalc <= 1'b1;
         end
         if (div_done) begin
            high_time <= div_high;
         end
      end
   end

   // High time from this channel's own period and duty
   spwm_high_time u_high_time (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_start(recalc && !div_busy),
      .i_period(period),
      .i_duty(duty),
      .o_busy(div_busy),
      .o_done(div_done),
      .o_high(div_high)
   );

   // Enable history for the run request
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         en_q <= 1'b0;
      end else begin
         en_q <= ctl_en;
      end
   end

   // Waveform scheduler
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= spwm_pkg::ST_IDLE;
         o_pwm <= 1'b0;
         rise_armed <= 1'b0;
         rise_tgt <= '0;
         fall_tgt <= '0;
      end else if (!ctl_en) begin
         // Disabled: output low, nothing scheduled
         state <= spwm_pkg::ST_IDLE;
         o_pwm <= 1'b0;
         rise_armed <= 1'b0;
      end else if (start) begin
         // Master schedules its first rise, slave waits for a link
         state <= spwm_pkg::ST_LOW;
         rise_tgt <= first_rise;
         rise_armed <= !ctl_slave;
      end else begin
         if (fall_evt) begin
            o_pwm <= 1'b0;
            state <= spwm_pkg::ST_LOW;
         end
         if (rise_evt) begin
            fall_tgt <= rise_tgt + spwm_pkg::TB_W'(high_time);
            o_pwm <= high_nz;
            state <= (high_nz && !high_full) ? spwm_pkg::ST_HIGH : spwm_pkg::ST_LOW;
            if (!ctl_slave) begin
               rise_tgt <= rise_tgt + spwm_pkg::TB_W'(period);
            end else begin
               rise_armed <= 1'b0;
            end
         end
         // A link from any source; masters never take one
         if (link_take) begin
            rise_tgt <= slave_tgt;
            rise_armed <= 1'b1;
         end
      end
   end

   // Stamp writes, links and service requests
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_mem_wr_en <= 1'b0;
         o_mem_wr_addr <= '0;
         o_mem_wr_data <= '0;
         o_link_req <= 8'h00;
         o_irq_req <= 1'b0;
         o_dma_req <= 1'b0;
      end else begin
         o_mem_wr_en <= rise_evt;
         o_link_req <= 8'h00;
         o_irq_req <= 1'b0;
         o_dma_req <= 1'b0;
         if (rise_evt) begin
            o_mem_wr_addr <= stamp_addr;
            o_mem_wr_data <= tb_sel;
            if (!ctl_slave) begin
               o_link_req <= link_mask;
               o_irq_req <= 1'b1;
               o_dma_req <= 1'b1;
            end
         end
         if (fall_evt && !ctl_slave && ctl_fall) begin
            o_irq_req <= 1'b1;
            o_dma_req <= 1'b1;
         end
      end
   end

   property p_stamp;
      @(posedge i_clock) disable iff (!i_rst_b)
      rise_evt |=> o_mem_wr_en && (o_mem_wr_data == $past(tb_sel)) &&
         (o_mem_wr_addr == $past(stamp_addr));
   endproperty
   a_stamp: assert property (p_stamp) else $error("Rise stamp not written");

   property p_rise_req;
      @(posedge i_clock) disable iff (!i_rst_b)
      (rise_evt && !ctl_slave) |=> (o_irq_req && o_dma_req) ##1
         (o_irq_req == $past(rise_evt || (fall_evt && ctl_fall)));
   endproperty
   a_rise_req: assert property (p_rise_req) else $error("Master rise request wrong");

   property p_fall_quiet;
      @(posedge i_clock) disable iff (!i_rst_b)
      (fall_evt && !ctl_fall) |=> !o_irq_req && !o_dma_req;
   endproperty
   a_fall_quiet: assert property (p_fall_quiet) else $error("Falling request unasked");

   property p_links;
      @(posedge i_clock) disable iff (!i_rst_b)
      (rise_evt && !ctl_slave) |=> (o_link_req == $past(link_mask));
   endproperty
   a_links: assert property (p_links) else $error("Links not sent on rise");

   property p_duty_zero;
      @(posedge i_clock) disable iff (!i_rst_b)
      (rise_evt && !high_nz && ctl_en) |=> !o_pwm;
   endproperty
   a_duty_zero: assert property (p_duty_zero) else $error("Zero duty went high");

   property p_duty_full;
      @(posedge i_clock) disable iff (!i_rst_b)
      (rise_evt && high_nz && high_full && ctl_en) |=>
         o_pwm && (state == spwm_pkg::ST_LOW);
   endproperty
   a_duty_full: assert property (p_duty_full) else $error("Full duty scheduled a fall");

   property p_slave_ref;
      @(posedge i_clock) disable iff (!i_rst_b)
      (link_take && ctl_en && !start) |=>
         rise_armed && (rise_tgt == $past(i_mem_rd_data) + spwm_pkg::TB_W'($past(offset)));
   endproperty
   a_slave_ref: assert property (p_slave_ref) else $error("Slave rise not from reference");

   property p_first_rise;
      @(posedge i_clock) disable iff (!i_rst_b)
      (start && !ctl_slave) |=>
         (rise_tgt == $past(start_ref) + spwm_pkg::TB_W'($past(period))) && rise_armed;
   endproperty
   a_first_rise: assert property (p_first_rise) else $error("First rise misplaced");

   property p_master_deaf;
      @(posedge i_clock) disable iff (!i_rst_b)
      (i_link && !ctl_slave && !rise_evt && !start && ctl_en) |=> $stable(rise_tgt);
   endproperty
   a_master_deaf: assert property (p_master_deaf) else $error("Master took a link");
endmodule // spwm_channel

// ---- sim/spwm_far_side.sv ----
// Far-side model: free-running timebase counters and shared data memory
`timescale 1ns/1ps
module spwm_far_side (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_b,
   // Memory port from the channel
   input wire logic [spwm_pkg::MA_W-1:0] i_rd_addr,
   output logic [spwm_pkg::TB_W-1:0] o_rd_data,
   input wire logic i_wr_en,
   input wire logic [spwm_pkg::MA_W-1:0] i_wr_addr,
   input wire logic [spwm_pkg::TB_W-1:0] i_wr_data,
   // Timebase counters
   output logic [spwm_pkg::TB_W-1:0] o_tb1,
   output logic [spwm_pkg::TB_W-1:0] o_tb2
);
   logic [spwm_pkg::TB_W-1:0] mem [0:1023]; // Stamps and references
   // Combinational read, as the channel expects
   assign o_rd_data = mem[i_rd_addr];
   // Second counter runs at a quarter rate
   assign o_tb2 = {2'h0, o_tb1[23:2]};
   // Timebase wraps at full width
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tb1 <= 24'h000000;
      end else begin
         o_tb1 <= o_tb1 + 24'h000001;
      end
   end
   // Stamp writes; the bench may also plant references here
   always @(posedge i_clock) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end
endmodule // spwm_far_side

// ---- sim/synchronized_pwm_master_slave_tb_top.sv ----
// Testbench: register-bus tests of the synchronized PWM channel
`timescale 1ns/1ps
module synchronized_pwm_master_slave_tb_top;
   logic clk, rst_b, awv, wv, arv, link, bv, awr, wr, arr, rv, we, pwm, irq, dma, f;
   logic [7:0] awa, ara, lreq;
   logic [31:0] wd, rd, q;
   logic [1:0] bresp, rresp, r;
   logic [9:0] mra, mwa;
   logic [23:0] mrd, mwd, tb1, tb2, ref_t;
   int n_fail, checks, cyc, n, hi, lo;
   // Design and far side
   spwm_channel i_spwm_channel (.i_clock(clk), .i_rst_b(rst_b),
      .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr),
      .i_wdata(wd), .i_wstrb(4'hF), .o_bvalid(bv), .i_bready(1'b1), .o_bresp(bresp),
      .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv), .i_rready(1'b1),
      .o_rdata(rd), .o_rresp(rresp), .i_timebase_counter_1(tb1), .i_timebase_counter_2(tb2),
      .o_mem_rd_addr(mra), .i_mem_rd_data(mrd), .o_mem_wr_en(we), .o_mem_wr_addr(mwa),
      .o_mem_wr_data(mwd), .i_link(link), .o_link_req(lreq), .o_pwm(pwm),
      .o_irq_req(irq), .o_dma_req(dma));
   spwm_far_side i_spwm_far_side (.i_clock(clk), .i_rst_b(rst_b), .i_rd_addr(mra),
      .o_rd_data(mrd), .i_wr_en(we), .i_wr_addr(mwa), .i_wr_data(mwd), .o_tb1(tb1), .o_tb2(tb2));
   // Comparison with count
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One bus transfer; ready is judged at the negedge before the taking edge
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic ha, hw, hb;
      @(posedge clk);
      awa <= a;
      ara <= a;
      wd <= d;
      awv <= w;
      wv <= w;
      arv <= !w;
      hb = 1'b0;
      while (!hb) begin
         @(negedge clk);
         ha = w ? awr : arr;
         hw = wr;
         hb = w ? bv : rv;
         q = rd;
         r = w ? bresp : rresp;
         @(posedge clk);
         if (ha && (awv || arv)) begin
            awv <= 1'b0;
            arv <= 1'b0;
         end
         if (hw && wv) wv <= 1'b0;
      end
   endtask
   // Counts negedges while the waveform holds level v
   task cnt(input logic v, output int c);
      c = 0;
      do begin
         @(negedge clk);
         c++;
      end while (pwm === v && c < 500);
   endtask
   // Waits for a rise, then measures two whole periods
   task meas;
      cnt(1'b0, n);
      repeat (2) begin
         cnt(1'b1, hi);
         f = irq;
         cnt(1'b0, lo);
      end
   endtask
   // Verdict
   task close_out;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         close_out;
      end
   end
   // Test sequence
   initial begin
      {rst_b, awv, wv, arv, link, awa, ara, wd} = '0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      bus(1'b0, spwm_pkg::A_PERIOD, 32'h0);
      chk("period reset", 32'h0, q);
      bus(1'b0, 8'h28, 32'h0);
      chk("unmapped resp", {30'h0, spwm_pkg::RESP_SLVERR}, {30'h0, r});
      bus(1'b1, 8'h28, 32'h0);
      chk("unmapped wr resp", {30'h0, spwm_pkg::RESP_SLVERR}, {30'h0, r});
      bus(1'b1, spwm_pkg::A_DUTY, 32'h2EE0);
      bus(1'b0, spwm_pkg::A_DUTY, 32'h0);
      chk("duty clamp", 32'h2710, q);
      bus(1'b1, spwm_pkg::A_OFFSET, 32'hFFFFFFFF);
      bus(1'b0, spwm_pkg::A_OFFSET, 32'h0);
      chk("offset width", 32'h3FFFFF, q);
      $display("test regs done");
      bus(1'b1, spwm_pkg::A_PERIOD, 32'h64);
      bus(1'b1, spwm_pkg::A_DUTY, 32'h1388);
      bus(1'b1, spwm_pkg::A_STAMP_ADDR, 32'h3);
      bus(1'b1, spwm_pkg::A_LINK_MASK, 32'hA5);
      bus(1'b1, spwm_pkg::A_CTRL, 32'h11);
      cnt(1'b0, n);
      chk("links", 32'hA5, {24'h0, lreq});
      chk("irq dma", 32'h3, {30'h0, irq, dma});
      chk("stamp", {8'h0, tb1 - 24'h1}, {8'h0, mwd});
      chk("stamp addr", 32'h3, {22'h0, mwa});
      chk("stamp en", 32'h1, {31'h0, we});
      cnt(1'b1, hi);
      f = irq;
      cnt(1'b0, lo);
      chk("high", 32'd50, hi);
      chk("low", 32'd50, lo);
      chk("fall irq", 32'h1, {31'h0, f});
      bus(1'b0, spwm_pkg::A_HIGH_TIME, 32'h0);
      chk("high time", 32'd50, q);
      $display("test master done");
      bus(1'b1, spwm_pkg::A_DUTY, 32'h9C4);
      meas;
      chk("new high", 32'd25, hi);
      chk("new low", 32'd75, lo);
      bus(1'b1, spwm_pkg::A_CTRL, 32'h0);
      // Second timebase runs at a quarter rate, so ticks last four cycles
      bus(1'b1, spwm_pkg::A_CTRL, 32'h5);
      meas;
      chk("no fall irq", 32'h0, {31'h0, f});
      chk("tb2 high", 32'd100, hi);
      chk("period", 32'd400, hi + lo);
      $display("test update done");
      bus(1'b1, spwm_pkg::A_CTRL, 32'h0);
      bus(1'b1, spwm_pkg::A_OFFSET, 32'h14);
      bus(1'b1, spwm_pkg::A_REF_PTR, 32'h7);
      bus(1'b1, spwm_pkg::A_STAMP_ADDR, 32'h9);
      // Master started from a planted reference time
      ref_t = tb1 + 24'h000028;
      i_spwm_far_side.mem[7] <= ref_t;
      bus(1'b1, spwm_pkg::A_CTRL, 32'h9);
      cnt(1'b0, n);
      chk("ref start", {8'h0, ref_t + 24'h64}, {8'h0, mwd});
      bus(1'b1, spwm_pkg::A_CTRL, 32'h0);
      bus(1'b1, spwm_pkg::A_CTRL, 32'h3);
      ref_t = tb1 + 24'h000028;
      i_spwm_far_side.mem[7] <= ref_t;
      link <= 1'b1;
      @(posedge clk);
      link <= 1'b0;
      cnt(1'b0, n);
      chk("slave rise", {8'h0, ref_t + 24'h14}, {8'h0, mwd});
      chk("slave irq", 32'h0, {31'h0, irq});
      cnt(1'b1, hi);
      chk("slave high", 32'd25, hi);
      // Full duty holds high past a period, zero duty never rises
      bus(1'b1, spwm_pkg::A_DUTY, 32'h2710);
      repeat (40) @(posedge clk);
      link <= 1'b1;
      @(posedge clk);
      link <= 1'b0;
      cnt(1'b0, n);
      repeat (150) @(negedge clk);
      chk("full duty", 32'h1, {31'h0, pwm});
      bus(1'b1, spwm_pkg::A_DUTY, 32'h0);
      repeat (40) @(posedge clk);
      link <= 1'b1;
      @(posedge clk);
      link <= 1'b0;
      repeat (5) @(negedge clk);
      chk("zero duty", 32'h0, {31'h0, pwm});
      $display("test slave done");
      close_out;
   end
endmodule // synchronized_pwm_master_slave_tb_top
